// ==== logic/mdd_top.sv ====
// Purpose: Thermal, short, open-load, fault and index logic with APB access
// Assumes: Sensor and detector inputs synchronous to ref_clk_i
// Notes:   Zero-wait APB slave; unmapped addresses read zero, pslverr low
`timescale 1ns/1ps
module mdd_top (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Temperature sensor comparators, one per level: 120,143,150,157
    input  wire logic [3:0]  temp_above_i,
    // OTP defaults for thresholds
    input  wire logic [1:0]  otp_tsel_i,
    input  wire logic        otp_pwsel_i,
    // Bridge short detectors: ground A,B then supply A,B
    input  wire logic [3:0]  short_det_i,
    input  wire logic        short_retry_i,
    // Coil current reached per coil A,B
    input  wire logic [1:0]  coil_reached_i,
    // Motion status
    input  wire logic        stall_det_i,
    input  wire logic        step_exec_i,
    input  wire logic        mstep_zero_i,
    // Outputs
    output logic             bridge_a_en_o,
    output logic             bridge_b_en_o,
    output logic             fault_stall_output_o,
    output logic             index_o,
    output logic             irq_o
);
    import mdd_pkg::*;

    typedef struct packed {
        logic [31:0]         ctrl;
        logic                otp_loaded;
        logic                overtemp_shutdown_flag;
        logic                otpw;
        logic [MDD_NEVT-1:0] irq_st;
        logic [MDD_NEVT-1:0] irq_mk;
        logic [31:0]         prdata;
        logic                pready;
        logic                bra;
        logic                brb;
        logic                fault;
        logic                index;
        logic                irq;
    } mdd_top_type;

    mdd_top_type s_r;
    mdd_top_type s_nxt;

    mdd_evt_if sq [4] ();
    logic [3:0] sh_hit;
    logic [3:0] sh_lat;

    // ==========================================================
    // Short qualifiers, one per detector
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sq
            mdd_short_qual u_sq (
                .ref_clk_i (ref_clk_i),
                .rst_i     (rst_i),
                .drv_en_i  (s_r.ctrl[MDD_CTRL_EN]),
                .retry_i   (short_retry_i),
                .det_i     (short_det_i[gi]),
                .evt       (sq[gi])
            );
            assign sh_hit[gi] = sq[gi].hit;
            assign sh_lat[gi] = sq[gi].latched;
        end
    endgenerate

    wire logic bridge_a_short_ground_flag = sh_lat[0];
    wire logic bridge_b_short_ground_flag = sh_lat[1];
    wire logic bridge_a_short_supply_flag = sh_lat[2];
    wire logic bridge_b_short_supply_flag = sh_lat[3];

    // ==========================================================
    // Threshold decode
    mdd_tsel_type tsel;
    logic         sd_trip;
    logic         pw_level;
    logic [1:0]   ol;
    logic [MDD_NEVT-1:0] evt;
    logic [MDD_NEVT-1:0] status;
    logic         stall_act;
    logic         wr;
    logic         rd;

    assign tsel = mdd_tsel_type'(s_r.ctrl[MDD_CTRL_TSEL +: 2]);

    always_comb begin
        sd_trip  = temp_above_i[1];
        pw_level = temp_above_i[0];
        unique case (tsel)
            MDD_TS_143: begin
                sd_trip  = temp_above_i[1];
                pw_level = temp_above_i[0];
            end
            MDD_TS_150: begin
                sd_trip  = temp_above_i[2];
                pw_level = s_r.ctrl[MDD_CTRL_PWSEL] ? temp_above_i[1]
                                                    : temp_above_i[0];
            end
            MDD_TS_157: begin
                sd_trip  = temp_above_i[3];
                pw_level = temp_above_i[1];
            end
            default: begin
                sd_trip  = temp_above_i[1];
                pw_level = temp_above_i[0];
            end
        endcase
    end

    // Open-load: informative only, sets status and interrupt but no bridge or fault action
    assign ol        = ~coil_reached_i & {2{s_r.ctrl[MDD_CTRL_EN]}};
    assign stall_act = stall_det_i & s_r.ctrl[MDD_CTRL_STALLEN];
    assign wr        = psel_i & penable_i & pwrite_i;
    assign rd        = psel_i & ~penable_i & ~pwrite_i;

    always_comb begin
        status                = '0;
        status[MDD_ST_OVTMP]  = s_r.overtemp_shutdown_flag;
        status[MDD_ST_OTPW]   = pw_level;
        status[MDD_ST_GND_A]  = bridge_a_short_ground_flag;
        status[MDD_ST_GND_B]  = bridge_b_short_ground_flag;
        status[MDD_ST_S2VA]   = bridge_a_short_supply_flag;
        status[MDD_ST_S2VB]   = bridge_b_short_supply_flag;
        status[MDD_ST_OLA]    = ol[0];
        status[MDD_ST_OLB]    = ol[1];
        status[MDD_ST_STALL]  = stall_act;
        evt                   = '0;
        evt[MDD_ST_OVTMP]     = sd_trip & ~s_r.overtemp_shutdown_flag;
        evt[MDD_ST_OTPW]      = pw_level & ~s_r.otpw;
        evt[MDD_ST_GND_A]     = sh_hit[0];
        evt[MDD_ST_GND_B]     = sh_hit[1];
        evt[MDD_ST_S2VA]      = sh_hit[2];
        evt[MDD_ST_S2VB]      = sh_hit[3];
        evt[MDD_ST_OLA]       = ol[0];
        evt[MDD_ST_OLB]       = ol[1];
        evt[MDD_ST_STALL]     = stall_act;
    end

    // ==========================================================
    // Next state
    always_comb begin
        s_nxt        = s_r;
        s_nxt.pready = 1'b1;
        s_nxt.otpw   = pw_level;

        // Load OTP threshold choices once after reset; 157C is not reachable by OTP
        if (!s_r.otp_loaded) begin
            s_nxt.otp_loaded                   = 1'b1;
            s_nxt.ctrl[MDD_CTRL_TSEL +: 2]     = (otp_tsel_i == 2'b01) ? 2'b01 : 2'b00;
            s_nxt.ctrl[MDD_CTRL_PWSEL]         = otp_pwsel_i;
        end

        // Overtemperature shutdown holds until below pre-warning
        if (sd_trip) begin
            s_nxt.overtemp_shutdown_flag = 1'b1;
        end else if (!pw_level) begin
            s_nxt.overtemp_shutdown_flag = 1'b0;
        end

        // Register writes
        if (wr) begin
            unique case (paddr_i)
                MDD_OFS_CTRL:   s_nxt.ctrl   = pwdata_i;
                MDD_OFS_IRQ_MK: s_nxt.irq_mk = pwdata_i[MDD_NEVT-1:0];
                default: ;
            endcase
        end

        // Sticky interrupt status: set wins over write-one-to-clear
        if (wr && paddr_i == MDD_OFS_IRQ_ST) begin
            s_nxt.irq_st = s_r.irq_st & ~pwdata_i[MDD_NEVT-1:0];
        end
        s_nxt.irq_st = s_nxt.irq_st | evt;

        // Read data registered in setup phase
        if (rd) begin
            unique case (paddr_i)
                MDD_OFS_CTRL:   s_nxt.prdata = s_r.ctrl;
                MDD_OFS_STATUS: s_nxt.prdata = {{(32-MDD_NEVT){1'b0}}, status};
                MDD_OFS_IRQ_ST: s_nxt.prdata = {{(32-MDD_NEVT){1'b0}}, s_r.irq_st};
                MDD_OFS_IRQ_MK: s_nxt.prdata = {{(32-MDD_NEVT){1'b0}}, s_r.irq_mk};
                default:        s_nxt.prdata = 32'h0000_0000;
            endcase
        end

        // Bridges: off on shutdown or own short, only when driver enabled
        s_nxt.bra = s_r.ctrl[MDD_CTRL_EN] & ~s_nxt.overtemp_shutdown_flag
                    & ~sh_lat[0] & ~sh_lat[2];
        s_nxt.brb = s_r.ctrl[MDD_CTRL_EN] & ~s_nxt.overtemp_shutdown_flag
                    & ~sh_lat[1] & ~sh_lat[3];

        // Fault: driver cannot work normally, or enabled stall
        s_nxt.fault = s_nxt.overtemp_shutdown_flag | (|sh_lat) | stall_act;

        // Index: microstep zero, or toggle per step when selected
        if (s_r.ctrl[MDD_CTRL_STEPSEL]) begin
            s_nxt.index = s_r.index ^ step_exec_i;
        end else begin
            s_nxt.index = mstep_zero_i;
        end

        s_nxt.irq = |(s_nxt.irq_st & s_nxt.irq_mk);
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_r      <= '0;
            s_r.ctrl <= MDD_CTRL_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata_o             = s_r.prdata;
    assign pready_o             = s_r.pready;
    assign pslverr_o            = 1'b0;
    assign bridge_a_en_o        = s_r.bra;
    assign bridge_b_en_o        = s_r.brb;
    assign fault_stall_output_o = s_r.fault;
    assign index_o              = s_r.index;
    assign irq_o                = s_r.irq;

    // ==========================================================
    // Checks
    AST_OT_TRIP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        sd_trip |=> s_r.overtemp_shutdown_flag)
        else $error("shutdown trip did not set flag");
    AST_OT_HOLD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_r.overtemp_shutdown_flag && pw_level |=> s_r.overtemp_shutdown_flag)
        else $error("shutdown released above pre-warning");
    AST_OT_OFF: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_r.overtemp_shutdown_flag |-> !bridge_a_en_o && !bridge_b_en_o)
        else $error("bridge on during shutdown");
    AST_SHORT_A: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (sh_lat[0] || sh_lat[2]) |=> !bridge_a_en_o)
        else $error("bridge A on with short");
    AST_SHORT_B: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (sh_lat[1] || sh_lat[3]) |=> !bridge_b_en_o)
        else $error("bridge B on with short");
    AST_SHORT_B_ONLY: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (sh_lat[0] && !sh_lat[1] && !sh_lat[3] && s_r.ctrl[MDD_CTRL_EN]
         && !sd_trip && !s_r.overtemp_shutdown_flag) |=> bridge_b_en_o)
        else $error("bridge B disabled by bridge A short");
    AST_T157: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        tsel == MDD_TS_157 && temp_above_i[2] && !temp_above_i[3]
        && !s_r.overtemp_shutdown_flag |=> !s_r.overtemp_shutdown_flag)
        else $error("157 setting tripped early");
    AST_FAULT: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        stall_det_i && s_r.ctrl[MDD_CTRL_STALLEN] |=> fault_stall_output_o)
        else $error("stall not flagged on fault output");
    AST_SHORT_FAULT: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (|sh_lat) |=> fault_stall_output_o)
        else $error("short not flagged on fault output");
    AST_INDEX_STEP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_r.ctrl[MDD_CTRL_STEPSEL] && step_exec_i |=> index_o != $past(index_o))
        else $error("index did not toggle on step");
    AST_INDEX_ZERO: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !s_r.ctrl[MDD_CTRL_STEPSEL] |=> index_o == $past(mstep_zero_i))
        else $error("index does not follow microstep zero");
    AST_OL_INFO: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        ##1 (s_r.ctrl[MDD_CTRL_EN] && !sd_trip && !s_r.overtemp_shutdown_flag
        && sh_lat == 4'h0 && ol != 2'b00) |=> bridge_a_en_o && bridge_b_en_o)
        else $error("open load disabled a bridge");
    AST_OL_FLAG: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        ol[0] |=> s_r.irq_st[MDD_ST_OLA])
        else $error("open load A not recorded");
    AST_IRQ_LEVEL: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        irq_o == |(s_r.irq_st & s_r.irq_mk))
        else $error("interrupt output does not match status and mask");

endmodule

// ==== logic/mdd_pkg.sv ====
// Purpose: Constants and types for the motor driver diagnostics block
// Assumes: 32-bit APB register bus, 250 MHz clock
// Notes:   Register map and field positions live here
package mdd_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] MDD_OFS_CTRL   = 8'h00;
    localparam logic [7:0] MDD_OFS_STATUS = 8'h04;
    localparam logic [7:0] MDD_OFS_IRQ_ST = 8'h08;
    localparam logic [7:0] MDD_OFS_IRQ_MK = 8'h0c;

    // ==========================================================
    // Control fields
    localparam int MDD_CTRL_EN      = 0;
    localparam int MDD_CTRL_STALLEN = 1;
    localparam int MDD_CTRL_STEPSEL = 2;
    localparam int MDD_CTRL_TSEL    = 4;
    localparam int MDD_CTRL_PWSEL   = 6;

    localparam logic [31:0] MDD_CTRL_RST = 32'h0000_0000;

    // ==========================================================
    // Status / interrupt bit positions
    localparam int MDD_ST_OVTMP = 0;
    localparam int MDD_ST_OTPW  = 1;
    localparam int MDD_ST_GND_A = 2;
    localparam int MDD_ST_GND_B = 3;
    localparam int MDD_ST_S2VA  = 4;
    localparam int MDD_ST_S2VB  = 5;
    localparam int MDD_ST_OLA   = 6;
    localparam int MDD_ST_OLB   = 7;
    localparam int MDD_ST_STALL = 8;
    localparam int MDD_NEVT     = 9;

    // ==========================================================
    // Temperature levels, degrees C, and sensor level codes
    localparam int MDD_T_120 = 120;
    localparam int MDD_T_143 = 143;
    localparam int MDD_T_150 = 150;
    localparam int MDD_T_157 = 157;

    // Shutdown threshold select
    typedef enum logic [1:0] {
        MDD_TS_143  = 2'b00,
        MDD_TS_150  = 2'b01,
        MDD_TS_157  = 2'b10,
        MDD_TS_RSVD = 2'b11
    } mdd_tsel_type;

    // Confirmations needed: first detect plus three retries
    localparam logic [1:0] MDD_SHORT_RETRIES = 2'd3;

endpackage

// ==== logic/mdd_evt_if.sv ====
// Purpose: Carries event flags from the short qualifiers to the top
// Assumes: One clock domain
// Notes:   Modport src for the qualifier, dst for the top
`timescale 1ns/1ps
interface mdd_evt_if;
    logic hit;
    logic latched;
    modport src (output hit, output latched);
    modport dst (input hit, input latched);
endinterface

// ==== logic/mdd_short_qual.sv ====
// Purpose: Qualifies one short detector with retries and latches it
// Assumes: Detector input synchronous to the clock
// Notes:   Latch clears only on the enable falling then rising
`timescale 1ns/1ps
module mdd_short_qual (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    // Control
    input  wire logic drv_en_i,
    input  wire logic retry_i,
    input  wire logic det_i,
    // Result
    mdd_evt_if.src    evt
);
    import mdd_pkg::*;

    typedef struct packed {
        logic [1:0] cnt;
        logic       latched;
        logic       seen_off;
        logic       hit;
    } mdd_sq_type;

    mdd_sq_type s_r;
    mdd_sq_type s_nxt;

    always_comb begin
        s_nxt     = s_r;
        s_nxt.hit = 1'b0;
        if (!drv_en_i) begin
            s_nxt.seen_off = s_r.latched;
            s_nxt.cnt      = 2'd0;
        end else if (s_r.seen_off) begin
            // Disable then re-enable restarts the bridge
            s_nxt.latched  = 1'b0;
            s_nxt.seen_off = 1'b0;
        end else if (!s_r.latched && retry_i) begin
            if (det_i) begin
                if (s_r.cnt == MDD_SHORT_RETRIES) begin
                    s_nxt.latched = 1'b1;
                    s_nxt.hit     = 1'b1;
                    s_nxt.cnt     = 2'd0;
                end else begin
                    s_nxt.cnt = s_r.cnt + 2'd1;
                end
            end else begin
                s_nxt.cnt = 2'd0;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign evt.hit     = s_r.hit;
    assign evt.latched = s_r.latched;

    AST_SQ_NEEDS_RETRIES: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $rose(s_r.latched) |-> $past(s_r.cnt) == MDD_SHORT_RETRIES)
        else $error("short latched without three retries");
    AST_SQ_HOLD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $fell(s_r.latched) |-> $past(s_r.seen_off) && $past(drv_en_i))
        else $error("short latch cleared without disable and re-enable");

endmodule

// ==== dv/mdd_host_model.sv ====
// Purpose: Host controller model that runs APB transfers for the bench
// Assumes: Requests are held by the bench until done_o pulses
// Notes:   Drives after the rising edge only; holds until pready is sampled
`timescale 1ns/1ps
module mdd_host_model (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    // Bench request side
    input  wire logic        req_i,
    input  wire logic        wr_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    output logic             done_o,
    output logic      [31:0] rdata_o,
    // APB master side
    output logic             psel_o,
    output logic             penable_o,
    output logic             pwrite_o,
    output logic      [7:0]  paddr_o,
    output logic      [31:0] pwdata_o,
    input  wire logic        pready_i,
    input  wire logic [31:0] prdata_i
);
    // ==========================================================
    // Setup, access, release
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            psel_o    <= 1'b0;
            penable_o <= 1'b0;
            pwrite_o  <= 1'b0;
            paddr_o   <= 8'h00;
            pwdata_o  <= 32'h0000_0000;
            done_o    <= 1'b0;
            rdata_o   <= 32'h0000_0000;
        end else begin
            done_o <= 1'b0;
            if (psel_o && penable_o) begin
                if (pready_i) begin
                    psel_o    <= 1'b0;
                    penable_o <= 1'b0;
                    done_o    <= 1'b1;
                    rdata_o   <= prdata_i;
                    // Released bus shows no stale values
                    paddr_o   <= ~paddr_o;
                    pwdata_o  <= ~pwdata_o;
                end
            end else if (psel_o) begin
                penable_o <= 1'b1;
            end else if (req_i && !done_o) begin
                psel_o   <= 1'b1;
                pwrite_o <= wr_i;
                paddr_o  <= addr_i;
                pwdata_o <= wdata_i;
            end
        end
    end
endmodule

// ==== dv/mdd_top_tb_top.sv ====
// Purpose: Self-checking bench for the motor driver diagnostics block
// Assumes: Zero-wait APB slave, OTP sampled after each reset
// Notes:   Each scenario task drives and judges on its own
`timescale 1ns/1ps
module mdd_top_tb_top;
    import mdd_pkg::*;
    logic        ref_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        req = 1'b0, wr = 1'b0, done;
    logic [7:0]  addr = 8'h00, paddr;
    logic [31:0] wdata = 32'h0, rdata, pwdata, prdata;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [3:0]  temp_above_i = 4'h0, short_det_i = 4'h0;
    logic [1:0]  otp_tsel_i = 2'b00, coil_reached_i = 2'b11;
    logic        otp_pwsel_i = 1'b0, short_retry_i = 1'b0, stall_det_i = 1'b0;
    logic        step_exec_i = 1'b0, mstep_zero_i = 1'b0;
    logic        bra, brb, fault, index, irq;
    int          n_errors = 0, compares = 0;
    logic [31:0] rd;

    initial forever #2 ref_clk_i = ~ref_clk_i;

    mdd_host_model u_mdd_host_model (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_i(req),
        .wr_i(wr), .addr_i(addr), .wdata_i(wdata), .done_o(done), .rdata_o(rdata),
        .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
        .pwdata_o(pwdata), .pready_i(pready), .prdata_i(prdata));
    mdd_top u_mdd_top (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .temp_above_i(temp_above_i), .otp_tsel_i(otp_tsel_i), .otp_pwsel_i(otp_pwsel_i),
        .short_det_i(short_det_i), .short_retry_i(short_retry_i),
        .coil_reached_i(coil_reached_i), .stall_det_i(stall_det_i),
        .step_exec_i(step_exec_i), .mstep_zero_i(mstep_zero_i), .bridge_a_en_o(bra),
        .bridge_b_en_o(brb), .fault_stall_output_o(fault), .index_o(index), .irq_o(irq));

    // ==========================================================
    // Helpers
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        req <= 1'b1;
        wr <= w;
        addr <= a;
        wdata <= d;
        k = 0;
        do begin
            @(posedge ref_clk_i);
            k++;
        end while (done !== 1'b1 && k < 50);
        if (k >= 50) begin
            n_errors++;
            $display("[ERR] %0t bus transfer hung", $time);
        end
        rd = rdata;
        req <= 1'b0;
        cyc(1);
    endtask
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp, input string m);
        chk32({31'h0, got}, {31'h0, exp}, m);
    endtask
    function automatic logic [31:0] ctl(logic st, logic sm, logic [1:0] ts, logic pw);
        return (32'h1 << MDD_CTRL_EN) | ({31'h0, st} << MDD_CTRL_STALLEN)
            | ({31'h0, sm} << MDD_CTRL_STEPSEL) | ({30'h0, ts} << MDD_CTRL_TSEL)
            | ({31'h0, pw} << MDD_CTRL_PWSEL);
    endfunction
    task automatic pulse(input int which);
        if (which == 0) begin
            short_retry_i <= 1'b1;
        end else begin
            step_exec_i <= 1'b1;
        end
        cyc(1);
        short_retry_i <= 1'b0;
        step_exec_i <= 1'b0;
        cyc(1);
    endtask
    task automatic do_reset;
        rst_i <= 1'b1;
        cyc(2);
        rst_i <= 1'b0;
        cyc(2);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_otp_regs;
        logic [1:0] ot [3] = '{2'b00, 2'b10, 2'b01};
        logic [31:0] ex [3] = '{32'h00, 32'h00, 32'h50};
        for (int i = 0; i < 3; i++) begin
            otp_tsel_i <= ot[i];
            otp_pwsel_i <= i[1];
            do_reset();
            bus(1'b0, MDD_OFS_CTRL, 32'h0);
            chk32(rd, ex[i], "otp ctrl");
        end
        bus(1'b1, MDD_OFS_STATUS, 32'hffff_ffff);
        bus(1'b0, MDD_OFS_STATUS, 32'h0);
        chk32(rd, 32'h0, "status ro");
        bus(1'b0, 8'h10, 32'h0);
        chk32(rd, 32'h0, "unmapped");
        chk1(pslverr, 1'b0, "pslverr");
    endtask
    task automatic t_thermal;
        int sh [5] = '{MDD_T_143, MDD_T_150, MDD_T_150, MDD_T_157, MDD_T_143};
        int pw [5] = '{MDD_T_120, MDD_T_120, MDD_T_143, MDD_T_143, MDD_T_120};
        logic [1:0] ts [5] = '{MDD_TS_143, MDD_TS_150, MDD_TS_150, MDD_TS_157, MDD_TS_RSVD};
        int tv [4];
        logic ex [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
        for (int c = 0; c < 5; c++) begin
            bus(1'b1, MDD_OFS_CTRL, ctl(1'b0, 1'b0, ts[c], c[1]));
            tv = '{sh[c] - 1, sh[c] + 1, pw[c] + 1, pw[c] - 1};
            for (int s = 0; s < 4; s++) begin
                temp_above_i <= {tv[s] > MDD_T_157, tv[s] > MDD_T_150,
                                 tv[s] > MDD_T_143, tv[s] > MDD_T_120};
                cyc(4);
                bus(1'b0, MDD_OFS_STATUS, 32'h0);
                chk1(rd[MDD_ST_OVTMP], ex[s], "shutdown flag");
                chk1(bra | brb, ~ex[s], "stage off");
                chk1(fault, ex[s], "fault on shutdown");
            end
            temp_above_i <= 4'h0;
        end
    endtask
    task automatic t_short;
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, MDD_OFS_CTRL, ctl(1'b0, 1'b0, 2'b00, 1'b0));
            short_det_i <= 4'h1 << i;
            repeat (3) pulse(0);
            cyc(3);
            chk1(bra & brb, 1'b1, "no early trip");
            pulse(0);
            cyc(3);
            chk1(i[0] ? brb : bra, 1'b0, "bridge off");
            chk1(i[0] ? bra : brb, 1'b1, "other bridge on");
            chk1(fault, 1'b1, "fault on short");
            short_det_i <= 4'h0;
            cyc(4);
            bus(1'b0, MDD_OFS_STATUS, 32'h0);
            chk32(rd & 32'h3c, 32'h1 << (MDD_ST_GND_A + i), "short flag");
            chk1(i[0] ? brb : bra, 1'b0, "stays off");
            bus(1'b1, MDD_OFS_CTRL, 32'h0);
            bus(1'b1, MDD_OFS_CTRL, ctl(1'b0, 1'b0, 2'b00, 1'b0));
            cyc(3);
            chk1(bra & brb, 1'b1, "restart");
        end
    endtask
    task automatic t_openload;
        repeat (16) pulse(1);
        coil_reached_i <= 2'b01;
        cyc(4);
        bus(1'b0, MDD_OFS_STATUS, 32'h0);
        chk32(rd & 32'hc0, 32'h1 << MDD_ST_OLB, "open load");
        chk1(bra & brb & ~fault, 1'b1, "no action");
        coil_reached_i <= 2'b11;
    endtask
    task automatic t_stall_irq;
        for (int e = 0; e < 2; e++) begin
            bus(1'b1, MDD_OFS_CTRL, ctl(e[0], 1'b0, 2'b00, 1'b0));
            stall_det_i <= 1'b1;
            cyc(3);
            chk1(fault, e[0], "stall fault");
            stall_det_i <= 1'b0;
            cyc(3);
        end
        bus(1'b0, MDD_OFS_IRQ_ST, 32'h0);
        chk1(rd[MDD_ST_STALL], 1'b1, "irq sticky");
        chk1(irq, 1'b0, "irq masked");
        bus(1'b1, MDD_OFS_IRQ_MK, 32'h1 << MDD_ST_STALL);
        cyc(1);
        chk1(irq, 1'b1, "irq raised");
        bus(1'b1, MDD_OFS_IRQ_ST, 32'hffff_ffff);
        bus(1'b0, MDD_OFS_IRQ_ST, 32'h0);
        chk32(rd, 32'h0, "irq cleared");
        chk1(irq, 1'b0, "irq low");
    endtask
    task automatic t_index;
        logic prev;
        bus(1'b1, MDD_OFS_CTRL, ctl(1'b0, 1'b0, 2'b00, 1'b0));
        for (int v = 1; v >= 0; v--) begin
            mstep_zero_i <= v[0];
            cyc(3);
            chk1(index, v[0], "index zero mark");
        end
        bus(1'b1, MDD_OFS_CTRL, ctl(1'b0, 1'b1, 2'b00, 1'b0));
        cyc(2);
        for (int s = 0; s < 3; s++) begin
            prev = index;
            pulse(1);
            cyc(1);
            chk1(index, ~prev, "index toggle");
        end
    endtask

    // ==========================================================
    // Sequence and verdict
    task automatic summarize;
        if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        do_reset();
        t_otp_regs();
        t_thermal();
        t_short();
        t_openload();
        t_stall_irq();
        t_index();
        summarize();
    end
    initial begin
        #200000;
        n_errors++;
        summarize();
    end
endmodule
